/* common/smc_timing_pkg.sv */
// Constants, carrier types and code decoders for the static memory cycle timing block.
// Assumes one master clock domain and an AHB-Lite register port of 32-bit words.
package smc_timing_pkg;

	// Register map: one 16-byte group per chip select, status word after them
	localparam logic [3:0] SETUP_OFS = 4'h0;
	localparam logic [3:0] PULSE_OFS = 4'h4;
	localparam logic [3:0] CYCLE_OFS = 4'h8;
	localparam logic [3:0] MODE_OFS = 4'hC;
	localparam logic [7:0] STATUS_ADDR = 8'h80;

	// Reset values
	localparam logic [31:0] SETUP_RESET = 32'h00000000;
	localparam logic [31:0] PULSE_RESET = 32'h01010101;
	localparam logic [31:0] CYCLE_RESET = 32'h00030003;
	localparam logic [31:0] MODE_RESET = 32'h00000003;

	// Field positions inside setup and pulse words
	localparam int WE_LSB = 0;
	localparam int CS_WR_LSB = 8;
	localparam int RD_LSB = 16;
	localparam int CS_RD_LSB = 24;
	// Field positions inside cycle and mode words
	localparam int WR_CYCLE_LSB = 0;
	localparam int RD_CYCLE_LSB = 16;
	localparam int READ_MODE_BIT = 0;
	localparam int WRITE_MODE_BIT = 1;
	localparam int BYTE_WRITE_BIT = 8;
	localparam int WIDTH_LSB = 12;

	// Data bus width codes
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;

	// Cycle counter width, enough for the largest cycle code (895)
	localparam int CW = 10;

	typedef enum logic [1:0] {IDLE, ACTIVE, EXTRA} state_type;

	// Timing of the access in flight, latched when it starts
	typedef struct packed {
		logic [CW-1:0] st_setup;
		logic [CW-1:0] st_pulse;
		logic [CW-1:0] cs_setup;
		logic [CW-1:0] cs_pulse;
		logic [CW-1:0] total;
		logic [CW-1:0] ctl_on;
		logic [CW-1:0] ctl_last;
		logic extra;
	} phase_type;

	// One access request from the system side
	typedef struct packed {
		logic write;
		logic [2:0] cs;
		logic [25:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic [1:0] width;
		logic byte_write;
	} access_type;

	// Setup code: bit 5 weighs 128
	function automatic logic [CW-1:0] setup_cycles(input logic [5:0] code);
		setup_cycles = {2'h0, code[5], 2'h0, code[4:0]};
	endfunction

	// Pulse code: bit 6 weighs 256
	function automatic logic [CW-1:0] pulse_cycles(input logic [6:0] code);
		pulse_cycles = {1'h0, code[6], 2'h0, code[5:0]};
	endfunction

	// Cycle code: bits 8:7 weigh 256
	function automatic logic [CW-1:0] cycle_cycles(input logic [8:0] code);
		cycle_cycles = {code[8:7], 1'h0, code[6:0]};
	endfunction

endpackage

/* rtl/static_memory_cycle_timing.sv */
// Timing generator of a static memory controller: strobe and chip-select waveforms per chip select.
// Assumes accesses arrive on mclk, registers are reached over AHB-Lite, memory data input is asynchronous.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module static_memory_cycle_timing #(
	parameter int NUM_CS = 6 // Number of chip selects
) (
	input wire logic mclk, // Master clock, 200 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic req_valid, // Access request
	input wire logic req_write, // Access is a write
	input wire logic [2:0] req_cs, // Chip select index
	input wire logic [25:0] req_addr, // Byte address in the chip select space
	input wire logic [31:0] req_wdata, // Write data
	input wire logic [3:0] req_be, // Byte enables
	output logic req_ready, // Request taken at this edge when valid
	output logic rd_valid, // One-cycle pulse with read data
	output logic [31:0] rd_data, // Captured read data
	output logic [25:0] mem_addr, // Memory address bus
	output logic [NUM_CS-1:0] chip_select_low, // Chip selects, active low
	output logic read_strobe_low, // Read strobe, active low
	output logic write_strobe_low, // Write strobe, active low
	output logic [3:0] byte_write_strobe_low, // Per-byte write strobes, active low
	output logic [3:0] byte_select_low, // Byte selects, active low
	output logic [31:0] mem_dout, // Data to memory
	output logic mem_doe_n, // Data output enable, low while driving
	input wire logic [31:0] mem_din // Data from memory, asynchronous
);

	// Programming words, one group per chip select
	logic [31:0] setup_reg [NUM_CS];
	logic [31:0] pulse_reg [NUM_CS];
	logic [31:0] cycle_reg [NUM_CS];
	logic [31:0] mode_reg [NUM_CS];

	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;

	smc_timing_pkg::state_type state_reg, state_next;
	logic [smc_timing_pkg::CW-1:0] cnt_reg, cnt_next;
	smc_timing_pkg::phase_type tim_reg, tim_next;
	smc_timing_pkg::access_type acc_reg, acc_next;
	logic ready_reg, ready_next;
	logic take;
	logic last;

	logic [31:0] din_meta_reg, din_sync_reg;
	logic [31:0] rd_data_reg;
	logic rd_valid_reg;
	logic [1:0] cap_pipe_reg;

	logic [25:0] addr_reg, addr_next;
	logic [NUM_CS-1:0] cs_low_reg, cs_low_next;
	logic rd_low_reg, rd_low_next;
	logic we_low_reg, we_low_next;
	logic [3:0] bw_low_reg, bw_low_next;
	logic [3:0] bs_low_reg, bs_low_next;
	logic [31:0] dout_reg, dout_next;
	logic doe_n_reg, doe_n_next;

	// Word offset in a group and the group's chip select
	function automatic logic [31:0] reg_word(input logic [7:0] a, input logic [31:0] s,
		input logic [31:0] p, input logic [31:0] c, input logic [31:0] m);
		case (a[3:0])
			smc_timing_pkg::SETUP_OFS: reg_word = s;
			smc_timing_pkg::PULSE_OFS: reg_word = p;
			smc_timing_pkg::CYCLE_OFS: reg_word = c;
			smc_timing_pkg::MODE_OFS: reg_word = m;
			default: reg_word = 32'h00000000;
		endcase
	endfunction

	// Cycle t inside a window in cycles: [from, from+len)
	function automatic logic in_window(input logic [smc_timing_pkg::CW-1:0] t,
		input logic [smc_timing_pkg::CW-1:0] from, input logic [smc_timing_pkg::CW-1:0] len);
		in_window = (t >= from) && (t < from + len);
	endfunction

	// AHB address phase capture; slave never stalls, so hreadyout is high from the second cycle after reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hreadyout_reg <= 1'b0;
		end
		else
		begin
			hreadyout_reg <= 1'b1;
			wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// Read data is fetched in the address phase; a read right after a write to the same word sees the old value
	always_ff @(posedge mclk)
	begin
		if (rst)
			hrdata_reg <= 32'h00000000;
		else if (hsel && hready && htrans[1] && !hwrite)
		begin
			if (haddr[7:0] == smc_timing_pkg::STATUS_ADDR)
				hrdata_reg <= {24'h000000, acc_reg.write, acc_reg.cs, 2'h0, state_reg};
			else if (haddr[7:4] < 4'(NUM_CS))
				hrdata_reg <= reg_word(haddr[7:0], setup_reg[haddr[6:4]], pulse_reg[haddr[6:4]],
					cycle_reg[haddr[6:4]], mode_reg[haddr[6:4]]);
			else
				hrdata_reg <= 32'h00000000;
		end
	end

	// Register writes in the data phase; unmapped offsets are ignored
	genvar g;
	generate
		for (g = 0; g < NUM_CS; g++)
		begin : grp
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					setup_reg[g] <= smc_timing_pkg::SETUP_RESET;
					pulse_reg[g] <= smc_timing_pkg::PULSE_RESET;
					cycle_reg[g] <= smc_timing_pkg::CYCLE_RESET;
					mode_reg[g] <= smc_timing_pkg::MODE_RESET;
				end
				else if (wr_pend_reg && wr_addr_reg[7:4] == 4'(g))
				begin
					case (wr_addr_reg[3:0])
						smc_timing_pkg::SETUP_OFS: setup_reg[g] <= hwdata;
						smc_timing_pkg::PULSE_OFS: pulse_reg[g] <= hwdata;
						smc_timing_pkg::CYCLE_OFS: cycle_reg[g] <= hwdata;
						smc_timing_pkg::MODE_OFS: mode_reg[g] <= hwdata;
						default: ;
					endcase
				end
			end
		end
	endgenerate

	assign take = req_valid && ready_reg;
	assign last = (cnt_reg + 10'h001 >= tim_reg.total);

	// Decode the request's timing; values are frozen for the whole access
	always_comb
	begin
		logic [31:0] s, p, c, m;
		logic rmode, wmode;
		logic [smc_timing_pkg::CW-1:0] hold;
		s = setup_reg[req_cs];
		p = pulse_reg[req_cs];
		c = cycle_reg[req_cs];
		m = mode_reg[req_cs];
		rmode = m[smc_timing_pkg::READ_MODE_BIT];
		wmode = m[smc_timing_pkg::WRITE_MODE_BIT];
		hold = 10'h000;
		tim_next = tim_reg;
		acc_next = acc_reg;
		if (take)
		begin
			acc_next = '{req_write, req_cs, req_addr, req_wdata, req_be,
				m[smc_timing_pkg::WIDTH_LSB +: 2], m[smc_timing_pkg::BYTE_WRITE_BIT]};
			if (req_write)
			begin
				// Write strobe and write chip-select phases
				tim_next.st_setup = smc_timing_pkg::setup_cycles(s[smc_timing_pkg::WE_LSB +: 6]);
				tim_next.st_pulse = smc_timing_pkg::pulse_cycles(p[smc_timing_pkg::WE_LSB +: 7]);
				tim_next.cs_setup = smc_timing_pkg::setup_cycles(s[smc_timing_pkg::CS_WR_LSB +: 6]);
				tim_next.cs_pulse = smc_timing_pkg::pulse_cycles(p[smc_timing_pkg::CS_WR_LSB +: 7]);
				tim_next.total = smc_timing_pkg::cycle_cycles(c[smc_timing_pkg::WR_CYCLE_LSB +: 9]);
				// Data drive starts at the end of the controlling setup
				tim_next.ctl_on = wmode ? tim_next.st_setup : tim_next.cs_setup;
				tim_next.ctl_last = tim_next.total;
				hold = tim_next.total - tim_next.st_setup - tim_next.st_pulse;
				tim_next.extra = wmode && (hold == 10'h000);
			end
			else
			begin
				// Read strobe and read chip-select phases
				tim_next.st_setup = smc_timing_pkg::setup_cycles(s[smc_timing_pkg::RD_LSB +: 6]);
				tim_next.st_pulse = smc_timing_pkg::pulse_cycles(p[smc_timing_pkg::RD_LSB +: 7]);
				tim_next.cs_setup = smc_timing_pkg::setup_cycles(s[smc_timing_pkg::CS_RD_LSB +: 6]);
				tim_next.cs_pulse = smc_timing_pkg::pulse_cycles(p[smc_timing_pkg::CS_RD_LSB +: 7]);
				tim_next.total = smc_timing_pkg::cycle_cycles(c[smc_timing_pkg::RD_CYCLE_LSB +: 9]);
				tim_next.ctl_on = tim_next.total;
				// Sample point is picked by read mode alone, no edge comparison
				tim_next.ctl_last = rmode ? (tim_next.st_setup + tim_next.st_pulse - 10'h001)
					: (tim_next.cs_setup + tim_next.cs_pulse - 10'h001);
				tim_next.extra = 1'b0;
			end
		end
	end

	// Sequencer: a new access may start right after the last cycle, with no gap
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			smc_timing_pkg::IDLE:
			begin
				if (take)
				begin
					state_next = smc_timing_pkg::ACTIVE;
					cnt_next = 10'h000;
				end
			end
			smc_timing_pkg::ACTIVE:
			begin
				if (last && tim_reg.extra)
					state_next = smc_timing_pkg::EXTRA;
				else if (last && take)
					cnt_next = 10'h000;
				else if (last)
					state_next = smc_timing_pkg::IDLE;
				else
					cnt_next = cnt_reg + 10'h001;
			end
			smc_timing_pkg::EXTRA:
			begin
				state_next = take ? smc_timing_pkg::ACTIVE : smc_timing_pkg::IDLE;
				cnt_next = 10'h000;
			end
			default:
			begin
				state_next = smc_timing_pkg::IDLE;
				cnt_next = 10'h000;
			end
		endcase
		// Ready during the final cycle so that back-to-back accesses abut
		ready_next = (state_next == smc_timing_pkg::IDLE) || (state_next == smc_timing_pkg::EXTRA)
			|| (cnt_next + 10'h001 >= tim_next.total && !tim_next.extra);
	end

	// Pin values for the coming cycle, registered so every pin comes from a flop
	always_comb
	begin
		logic st_on, cs_on;
		st_on = in_window(cnt_next, tim_next.st_setup, tim_next.st_pulse);
		cs_on = in_window(cnt_next, tim_next.cs_setup, tim_next.cs_pulse);
		addr_next = addr_reg;
		cs_low_next = '1;
		rd_low_next = 1'b1;
		we_low_next = 1'b1;
		bw_low_next = 4'hF;
		bs_low_next = 4'hF;
		dout_next = dout_reg;
		doe_n_next = 1'b1;
		case (state_next)
			smc_timing_pkg::ACTIVE:
			begin
				// Word address plus low bits for narrow devices
				if (acc_next.width == smc_timing_pkg::WIDTH_8)
					addr_next = acc_next.addr;
				else if (acc_next.width == smc_timing_pkg::WIDTH_16)
					addr_next = {acc_next.addr[25:1], 1'b0};
				else
					addr_next = {acc_next.addr[25:2], 2'h0};
				cs_low_next[acc_next.cs] = !cs_on;
				bs_low_next = acc_next.byte_write ? 4'hF : ~acc_next.be;
				if (acc_next.write)
				begin
					// Per-byte strobes share the write strobe waveform
					if (acc_next.byte_write)
						bw_low_next = ~(acc_next.be & {4{st_on}});
					else
						we_low_next = !st_on;
					dout_next = acc_next.wdata;
					doe_n_next = !(cnt_next >= tim_next.ctl_on);
				end
				else
					rd_low_next = !st_on;
			end
			smc_timing_pkg::EXTRA:
			begin
				// Strobe is up; address, selects and chip select hold one more cycle
				cs_low_next[acc_next.cs] = 1'b0;
				bs_low_next = acc_next.byte_write ? 4'hF : ~acc_next.be;
				doe_n_next = 1'b0;
			end
			default: ;
		endcase
	end

	// Sequencer and latched access state
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_reg <= smc_timing_pkg::IDLE;
			cnt_reg <= 10'h000;
			tim_reg <= '0;
			acc_reg <= '0;
			ready_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			tim_reg <= tim_next;
			acc_reg <= acc_next;
			ready_reg <= ready_next;
		end
	end

	// Memory pins; idle level is all strobes and selects high
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			addr_reg <= 26'h0000000;
			cs_low_reg <= '1;
			rd_low_reg <= 1'b1;
			we_low_reg <= 1'b1;
			bw_low_reg <= 4'hF;
			bs_low_reg <= 4'hF;
			dout_reg <= 32'h00000000;
			doe_n_reg <= 1'b1;
		end
		else
		begin
			addr_reg <= addr_next;
			cs_low_reg <= cs_low_next;
			rd_low_reg <= rd_low_next;
			we_low_reg <= we_low_next;
			bw_low_reg <= bw_low_next;
			bs_low_reg <= bs_low_next;
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
		end
	end

	// Two-flop synchroniser on the data pins; adds two cycles of latency to read data
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			din_meta_reg <= 32'h00000000;
			din_sync_reg <= 32'h00000000;
		end
		else
		begin
			din_meta_reg <= mem_din;
			din_sync_reg <= din_meta_reg;
		end
	end

	// Pins are sampled on the edge that raises the controlling signal
	// The mark waits two cycles so the synchronised copy of that very sample is kept
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cap_pipe_reg <= 2'h0;
			rd_data_reg <= 32'h00000000;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			cap_pipe_reg <= {cap_pipe_reg[0],
				state_reg == smc_timing_pkg::ACTIVE && !acc_reg.write && cnt_reg == tim_reg.ctl_last};
			rd_valid_reg <= cap_pipe_reg[1];
			if (cap_pipe_reg[1])
				rd_data_reg <= din_sync_reg;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign req_ready = ready_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign mem_addr = addr_reg;
	assign chip_select_low = cs_low_reg;
	assign read_strobe_low = rd_low_reg;
	assign write_strobe_low = we_low_reg;
	assign byte_write_strobe_low = bw_low_reg;
	assign byte_select_low = bs_low_reg;
	assign mem_dout = dout_reg;
	assign mem_doe_n = doe_n_reg;

endmodule

`default_nettype wire

/* sim/static_memory_cycle_timing_sva.sv */
// Checker of pin and bus timing relations of the timing block.
// Assumes one mclk domain with synchronous active-high rst; bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module cycle_timing_checker #(
	parameter int NUM_CS = 6 // Number of chip selects
) (
	input wire logic mclk, // Master clock
	input wire logic rst, // Synchronous reset
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Slave response
	input wire logic req_valid, // Access request
	input wire logic req_ready, // Access taken
	input wire logic rd_valid, // Read data pulse
	input wire logic [25:0] mem_addr, // Address bus
	input wire logic [NUM_CS-1:0] chip_select_low, // Chip selects
	input wire logic read_strobe_low, // Read strobe
	input wire logic write_strobe_low, // Write strobe
	input wire logic [3:0] byte_write_strobe_low, // Byte write strobes
	input wire logic [3:0] byte_select_low, // Byte selects
	input wire logic [31:0] mem_dout, // Write data
	input wire logic mem_doe_n // Data drive enable
);
	// Any write strobe low, plain or per byte
	wire logic wr_low = !write_strobe_low || !(&byte_write_strobe_low);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Port never stalls or errors once out of reset
	AST_AHB_OKAY: assert property (!$past(rst) |-> hreadyout && !hresp)
		else $error("bus port stalled or answered an error");
	// Capture pulse trails the sampling edge by two synchroniser cycles
	AST_RD_AFTER_LOW: assert property (rd_valid |-> !$past(read_strobe_low, 3) || !(&$past(chip_select_low, 3)))
		else $error("read data pulse without a preceding strobe");
	// Address and byte selects hold while the read strobe stays low
	AST_RD_ADDR: assert property (!read_strobe_low && !$past(read_strobe_low) && !($past(req_valid) && $past(req_ready)) |-> $stable({mem_addr, byte_select_low}))
		else $error("address moved under the read strobe");
	// Same for write strobes
	AST_WR_ADDR: assert property (wr_low && $past(wr_low) && !($past(req_valid) && $past(req_ready)) |-> $stable({mem_addr, byte_select_low}))
		else $error("address moved under the write strobe");
	// Driven data holds within one access
	AST_DOUT: assert property (!mem_doe_n && !$past(mem_doe_n) && !($past(req_valid) && $past(req_ready)) |-> $stable(mem_dout))
		else $error("write data changed while driven");
	// No drive while the memory may be driving
	AST_RD_NO_DRIVE: assert property (!read_strobe_low |-> mem_doe_n)
		else $error("data driven during read strobe");
	// Read and write strobes never overlap
	AST_RD_NO_WRITE: assert property (!read_strobe_low |-> write_strobe_low && (&byte_write_strobe_low))
		else $error("read and write strobes overlap");
	// Byte write strobes replace the plain strobe and byte selects
	AST_BYTE_WRITE: assert property (!(&byte_write_strobe_low) |-> write_strobe_low && (&byte_select_low))
		else $error("byte write strobe mixed with other strobes");
endmodule
`default_nettype wire

/* sim/async_sram_model.sv */
// Behavioural asynchronous memory on the far side of the timing block.
// Assumes 32-bit word addressing; sampled on mclk to record writes and the last word read.
`timescale 1ns/1ps
`default_nettype none
module async_sram_model #(
	parameter int NUM_CS = 6 // Number of chip selects
) (
	input wire logic mclk, // Sampling clock
	input wire logic [25:0] mem_addr, // Address
	input wire logic [NUM_CS-1:0] chip_select_low, // Selects
	input wire logic read_strobe_low, // Output enable
	input wire logic write_strobe_low, // Write enable
	input wire logic [3:0] byte_write_strobe_low, // Byte writes
	input wire logic [3:0] byte_select_low, // Byte selects
	input wire logic [31:0] mem_dout, // Data from block
	input wire logic mem_doe_n, // Block drives when low
	output logic [31:0] mem_din // Data to block
);
	logic [31:0] mem [256];
	logic [31:0] last;
	logic sel;
	logic rd;
	logic [3:0] wen;
	// Any select counts; word index from the aligned address
	assign sel = !(&chip_select_low);
	assign rd = sel && !read_strobe_low;
	assign wen = !write_strobe_low ? ~byte_select_low : ~byte_write_strobe_low;
	// Released bus shows the inverse of the last value, so a stale sample never matches
	assign mem_din = rd ? mem[mem_addr[9:2]] : ~last;
	always_ff @(posedge mclk)
		if (rd)
			last <= mem[mem_addr[9:2]];
	// Latches while enabled; the last value before release wins
	always_ff @(posedge mclk)
		for (int b = 0; b < 4; b++)
			if (sel && wen[b] && !mem_doe_n)
				mem[mem_addr[9:2]][8*b +: 8] <= mem_dout[8*b +: 8];
endmodule
`default_nettype wire

/* sim/static_memory_cycle_timing_bench.sv */
// Self-checking bench: register port, per-cycle read and write waveforms, capture, back-to-back reads.
// Assumes the timing block, its package, the memory model and the checker file.
`timescale 1ns/1ps
`default_nettype none
module static_memory_cycle_timing_bench;
	localparam int NUM_CS = 6;
	logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, req_valid, req_write, req_ready, rd_valid;
	logic read_strobe_low, write_strobe_low, mem_doe_n;
	logic [1:0] htrans;
	logic [2:0] hsize, req_cs;
	logic [3:0] req_be, byte_write_strobe_low, byte_select_low;
	logic [25:0] req_addr, mem_addr, ma;
	logic [31:0] haddr, hwdata, hrdata, req_wdata, rd_data, mem_dout, mem_din;
	logic [NUM_CS-1:0] chip_select_low;
	logic [15:0] smp [1024];
	int miscompares, n_tests;
	assign hready = hreadyout;

	static_memory_cycle_timing #(.NUM_CS(NUM_CS)) dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .mem_addr(mem_addr), .chip_select_low(chip_select_low), .read_strobe_low(read_strobe_low),
		.write_strobe_low(write_strobe_low), .byte_write_strobe_low(byte_write_strobe_low),
		.byte_select_low(byte_select_low), .mem_dout(mem_dout), .mem_doe_n(mem_doe_n), .mem_din(mem_din));
	async_sram_model #(.NUM_CS(NUM_CS)) mem_u (.mclk(mclk), .mem_addr(mem_addr), .chip_select_low(chip_select_low),
		.read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
		.byte_write_strobe_low(byte_write_strobe_low), .byte_select_low(byte_select_low), .mem_dout(mem_dout),
		.mem_doe_n(mem_doe_n), .mem_din(mem_din));

	// Clock, 5 ns period
	initial
	begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Code decoders written apart from the design's own
	function automatic int sd(input logic [5:0] c);
		return c[5] * 128 + c[4:0];
	endfunction
	function automatic int pd(input logic [6:0] c);
		return c[6] * 256 + c[5:0];
	endfunction
	function automatic int cd(input logic [8:0] c);
		return c[8:7] * 256 + c[6:0];
	endfunction

	// Single word transfer; read data is taken at the data phase's closing edge
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge mclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'h1);
		q = hrdata;
	endtask

	// One access; pins sampled mid-cycle for cycle indexes 0..n+2, read pulse trails by two
	task automatic access(input logic wr, input int n);
		req_valid <= 1'h1;
		req_write <= wr;
		do @(posedge mclk); while (req_ready !== 1'h1);
		req_valid <= 1'h0;
		for (int t = 0; t <= n + 2; t++)
		begin
			@(negedge mclk);
			if (t == 0)
				ma = mem_addr;
			smp[t] = {3'h0, rd_valid, mem_doe_n, byte_select_low, byte_write_strobe_low, write_strobe_low,
				read_strobe_low, chip_select_low[req_cs]};
		end
		@(posedge mclk);
	endtask

	task automatic test_regs;
		logic [31:0] q;
		for (int c = 0; c < 6; c += 5)
		begin
			ahb(1'h0, {24'h0, c[3:0], smc_timing_pkg::SETUP_OFS}, 32'h0, q);
			check(q, 32'h00000000);
			ahb(1'h0, {24'h0, c[3:0], smc_timing_pkg::PULSE_OFS}, 32'h0, q);
			check(q, 32'h01010101);
			ahb(1'h0, {24'h0, c[3:0], smc_timing_pkg::CYCLE_OFS}, 32'h0, q);
			check(q, 32'h00030003);
			ahb(1'h0, {24'h0, c[3:0], smc_timing_pkg::MODE_OFS}, 32'h0, q);
			check({30'h0, q[1:0]}, 32'h00000003);
		end
		// Unmapped word: writes vanish, reads give zero
		ahb(1'h1, 32'h00000090, 32'hFFFFFFFF, q);
		ahb(1'h0, 32'h00000090, 32'h0, q);
		check(q, 32'h0);
		$display("test register reset done");
	endtask

	// Program one select, write then read back, comparing strobes, selects and drive enable in every cycle of the access
	task automatic run_case(input logic [2:0] cs, input logic [31:0] su, input logic [31:0] pu,
		input logic [31:0] cy, input logic [31:0] md, input logic [3:0] be);
		logic [31:0] q, d, bm;
		logic [15:0] e, m;
		logic wr, lo, cl, in;
		int sp, pp, cs_s, cs_p, n, o1, o2;
		d = 32'hA5C30F10 ^ {29'h0, cs};
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		ahb(1'h1, {25'h0, cs, smc_timing_pkg::SETUP_OFS}, su, q);
		ahb(1'h1, {25'h0, cs, smc_timing_pkg::PULSE_OFS}, pu, q);
		ahb(1'h1, {25'h0, cs, smc_timing_pkg::CYCLE_OFS}, cy, q);
		ahb(1'h1, {25'h0, cs, smc_timing_pkg::MODE_OFS}, md, q);
		ahb(1'h0, {25'h0, cs, smc_timing_pkg::SETUP_OFS}, 32'h0, q);
		check(q, su);
		req_cs <= cs;
		req_addr <= {19'h0, cs, 4'h3};
		req_be <= be;
		req_wdata <= d;
		for (int ph = 0; ph < 2; ph++)
		begin
			wr = (ph == 0);
			o1 = wr ? smc_timing_pkg::WE_LSB : smc_timing_pkg::RD_LSB;
			o2 = wr ? smc_timing_pkg::CS_WR_LSB : smc_timing_pkg::CS_RD_LSB;
			sp = sd(su[o1 +: 6]);
			cs_s = sd(su[o2 +: 6]);
			pp = pd(pu[o1 +: 7]);
			cs_p = pd(pu[o2 +: 7]);
			n = cd(cy[(wr ? smc_timing_pkg::WR_CYCLE_LSB : smc_timing_pkg::RD_CYCLE_LSB) +: 9]);
			access(wr, n);
			for (int t = 0; t <= n + 2; t++)
			begin
				// Zero write hold under strobe control adds one held cycle
				in = t < n || (wr && md[1] && sp + pp == n && t == n);
				lo = t >= sp && t < sp + pp;
				cl = (t >= cs_s && t < cs_s + cs_p) || (in && t == n);
				e = {3'h0, !wr && t == (md[0] ? sp + pp : cs_s + cs_p) + 2, !(wr && in && t >= (md[1] ? sp : cs_s)),
					md[8] ? 4'hF : ~be, (wr && md[8]) ? ~(be & {4{lo}}) : 4'hF, !(wr && !md[8] && lo), !(!wr && lo), !cl};
				m = in ? 16'h1FFF : 16'h1000;
				check({16'h0, smp[t] & m}, {16'h0, e & m});
			end
			check({6'h0, ma}, {25'h0, cs, md[13] ? 4'h0 : (md[12] ? 4'h2 : 4'h3)});
		end
		check(rd_data & bm, d & bm);
		$display("test select %0d done", cs);
	endtask

	// Zero setup and hold: strobe and select stay low across two reads
	task automatic test_b2b;
		logic [31:0] q;
		ahb(1'h1, 32'h00000030, 32'h00000000, q);
		ahb(1'h1, 32'h00000034, 32'h02020101, q);
		ahb(1'h1, 32'h00000038, 32'h00020003, q);
		ahb(1'h1, 32'h0000003C, 32'h00002003, q);
		req_cs <= 3'h3;
		req_write <= 1'h0;
		req_valid <= 1'h1;
		do @(posedge mclk); while (req_ready !== 1'h1);
		for (int t = 0; t < 4; t++)
		begin
			@(negedge mclk);
			check({31'h0, read_strobe_low | chip_select_low[3]}, 32'h0);
			if (t == 1)
			begin
				check({31'h0, req_ready}, 32'h1);
				@(posedge mclk);
				req_valid <= 1'h0;
			end
		end
		@(posedge mclk);
		$display("test back-to-back reads done");
	endtask

	initial
	begin
		rst = 1'h1;
		hsel = 1'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		req_valid = 1'h0;
		req_write = 1'h0;
		req_cs = 3'h0;
		req_addr = 26'h0;
		req_wdata = 32'h0;
		req_be = 4'h0;
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		repeat (2) @(posedge mclk);
		test_regs;
		run_case(3'h1, 32'h01020001, 32'h05040503, 32'h00080007, 32'h00002003, 4'hF);
		run_case(3'h2, 32'h01010201, 32'h04050305, 32'h00070007, 32'h00002100, 4'h5);
		run_case(3'h5, 32'h21212121, 32'h42424242, 32'h01020102, 32'h00002003, 4'hF);
		run_case(3'h4, 32'h00000000, 32'h03030202, 32'h00030002, 32'h00001003, 4'hF);
		test_b2b;
		tally_and_finish;
	end

	// Tests need about 1200 cycles; 20000 means a hang
	initial
	begin
		#100000;
		miscompares++;
		tally_and_finish;
	end
endmodule

bind static_memory_cycle_timing cycle_timing_checker #(.NUM_CS(NUM_CS)) chk_u (.mclk(mclk), .rst(rst),
	.hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
	.mem_addr(mem_addr), .chip_select_low(chip_select_low), .read_strobe_low(read_strobe_low),
	.write_strobe_low(write_strobe_low), .byte_write_strobe_low(byte_write_strobe_low),
	.byte_select_low(byte_select_low), .mem_dout(mem_dout), .mem_doe_n(mem_doe_n));
`default_nettype wire
